// ===== core/upsp_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef UPSP_CONSTS_SVH
`define UPSP_CONSTS_SVH
// ----------------------------------------
// per-port register window and global registers, byte offsets
// ----------------------------------------
`define UPSP_PORT_STRIDE_BIT 6
`define UPSP_OFS_CTRL 6'h00
`define UPSP_OFS_CMD 6'h04
`define UPSP_OFS_STAT 6'h08
`define UPSP_OFS_RXST 6'h10
`define UPSP_OFS_RXP 6'h14
`define UPSP_OFS_TXBUF 6'h18
`define UPSP_OFS_RXBUF 6'h1C
`define UPSP_OFS_TMO 6'h20
`define UPSP_OFS_GSW 8'h80
`define UPSP_OFS_GERR 8'h84
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define UPSP_CMD_SEND 8
`define UPSP_CMD_RCV 9
`define UPSP_CMD_RXON 10
`define UPSP_RXP_START_EN 24
`define UPSP_RXP_END_EN 25
`define UPSP_RXP_ANY_EN 26
`define UPSP_PROTO_USER 2'h1
`define UPSP_RXST_RESET 8'h80
`define UPSP_ERR_SIM0 16'h0009
`define UPSP_ERR_SIM1 16'h000B
`define UPSP_ERR_MODE 16'h0100
`define UPSP_ERR_BUSY 16'h0101
`define UPSP_ERR_PARAM 16'h0102
`define UPSP_EVT_TX0 8'h09
`define UPSP_EVT_TX1 8'h1A
`define UPSP_EVT_RX0 8'h17
`define UPSP_EVT_RX1 8'h18
// ----------------------------------------
// timing
// ----------------------------------------
`define UPSP_CLK_HZ 100000000
`define UPSP_BREAK_BITS 5'h10
`define UPSP_BAUD0 38400
`define UPSP_BAUD1 19200
`define UPSP_BAUD2 9600
`define UPSP_BAUD3 4800
`define UPSP_BAUD4 2400
`define UPSP_BAUD5 1200
`define UPSP_BAUD6 115200
`define UPSP_BAUD7 57600
`endif

// ===== core/upsp_pkg.sv
// types shared by the serial port design
package upsp_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_BRK = 2'b10,
    TX_NEXT = 2'b11
  } upsp_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_HALF = 2'b01,
    RX_BITS = 2'b10
  } upsp_rx_e;
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic [7:0] tx_id;
    logic [7:0] rx_id;
  } upsp_evt_s;
endpackage

// ===== core/upsp_serial_port.sv
// user-controlled serial port with avalon-mm register access
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "upsp_consts.svh"
module upsp_serial_port
  import upsp_pkg::*;
#(
  parameter int NP = 2,
  parameter int CLK_HZ = `UPSP_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_mode,
  input wire logic mode_switch_pin,
  input wire logic [NP-1:0] ser_rxd,
  output logic [NP-1:0] ser_txd,
  output logic [NP-1:0] pd_serve,
  output logic [NP-1:0] tx_status_flag,
  output upsp_evt_s [NP-1:0] evt,
  output logic ok_output
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [16:0] baud_div(input logic [2:0] sel);
    int b;
    b = `UPSP_BAUD2;
    unique case (sel)
      3'h0: b = `UPSP_BAUD0;
      3'h1: b = `UPSP_BAUD1;
      3'h2: b = `UPSP_BAUD2;
      3'h3: b = `UPSP_BAUD3;
      3'h4: b = `UPSP_BAUD4;
      3'h5: b = `UPSP_BAUD5;
      3'h6: b = `UPSP_BAUD6;
      3'h7: b = `UPSP_BAUD7;
    endcase
    return 17'(CLK_HZ / b);
  endfunction

  // frame: start, data lsb first, optional parity, one stop, rest idle high
  function automatic logic [10:0] build_frame(input logic [7:0] c, input logic [7:0] d);
    logic [10:0] f;
    logic p;
    f = 11'h7FF;
    f[0] = 1'b0;
    p = (c[5] ? ^d[6:0] : ^d) ^ c[7];
    if (c[5]) begin
      f[7:1] = d[6:0];
      if (c[6]) f[8] = p;
    end else begin
      f[8:1] = d;
      if (c[6]) f[9] = p;
    end
    return f;
  endfunction

  // total bits on the line: start + data + parity + stop
  function automatic logic [4:0] frame_bits(input logic [7:0] c);
    return 5'(c[5] ? 9 : 10) + 5'(c[6]);
  endfunction

  // ----------------------------------------
  // bus decode and read path
  // ----------------------------------------
  logic rvalid_reg;
  logic [31:0] rd_port [NP];
  logic [31:0] rd_mux;
  logic [15:0] req_err [NP];
  logic [NP-1:0] req_hit;
  logic run_sw_reg;
  logic [15:0] err_reg;

  // one wait cycle on reads, none on writes
  assign avs_waitrequest = avs_read && !rvalid_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == `UPSP_OFS_GSW) rd_mux = {31'h0, run_sw_reg};
    else if (avs_address == `UPSP_OFS_GERR) rd_mux = {15'h0, ok_output, err_reg};
    else if (!avs_address[7] && int'(avs_address[6]) < NP)
      rd_mux = rd_port[int'(avs_address[6])];
  end

  // read data registered and held through the accepting edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rvalid_reg <= avs_read && !rvalid_reg;
      if (avs_read && !rvalid_reg) avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // mode switch synchroniser and request result
  // ----------------------------------------
  logic sw1_reg, sw2_reg, sw3_reg;
  logic run_q_reg;

  // switch position: 0 terminal, 1 run; taken once two stages agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw1_reg <= 1'b0;
      sw2_reg <= 1'b0;
      sw3_reg <= 1'b0;
      run_sw_reg <= 1'b0;
    end else begin
      sw1_reg <= mode_switch_pin;
      sw2_reg <= sw1_reg;
      sw3_reg <= sw2_reg;
      if (sw2_reg == sw3_reg) run_sw_reg <= sw3_reg;
    end
  end

  // ok flag and error code of the most recent request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ok_output <= 1'b1;
      err_reg <= 16'h0000;
      run_q_reg <= 1'b0;
    end else begin
      run_q_reg <= run_mode;
      for (int i = 0; i < NP; i++) begin
        if (req_hit[i]) begin
          ok_output <= (req_err[i] == 16'h0000);
          err_reg <= req_err[i];
        end
      end
    end
  end

  // ----------------------------------------
  // per-port logic
  // ----------------------------------------
  for (genvar g = 0; g < NP; g++) begin : gp
    logic [7:0] ctrl_reg;
    logic [31:0] rxp_reg;
    logic [15:0] tmo_reg;
    logic [7:0] rd_idx_reg;
    logic [7:0] tx_mem [256];
    logic [7:0] rx_mem [256];
    logic wr_here, cmd_wr, snd, receive_request, rxon, freeport, bad_param;
    logic [5:0] ofs;
    logic [16:0] div;
    upsp_tx_e tx_state;
    logic [7:0] tx_left_reg, tx_ptr_reg;
    logic [10:0] tx_frm_reg;
    logic [4:0] tx_bit_reg;
    logic [16:0] tx_tmr_reg;
    logic tx_flag_reg, tx_done_reg;
    logic rx1_reg, rx2_reg, rx3_reg, rx_lvl_reg;
    upsp_rx_e rx_state;
    logic [9:0] rx_bits_reg;
    logic [3:0] rx_idx_reg;
    logic [16:0] rx_tmr_reg;
    logic chr_vld_reg;
    logic [7:0] ch;
    logic perr;
    logic rx_act_reg, rx_started_reg, rx_done_reg;
    logic [7:0] rx_cnt_reg, rx_stat_reg;
    logic [32:0] tmo_cnt_reg;
    logic tmo_hit;

    assign ofs = avs_address[5:0];
    assign wr_here = avs_write && !avs_address[7] && (avs_address[6] == 1'(g));
    assign cmd_wr = wr_here && (ofs == `UPSP_OFS_CMD);
    assign snd = avs_writedata[`UPSP_CMD_SEND];
    assign receive_request = avs_writedata[`UPSP_CMD_RCV];
    assign rxon = avs_writedata[`UPSP_CMD_RXON];
    assign div = baud_div(ctrl_reg[4:2]);
    assign freeport = (ctrl_reg[1:0] == `UPSP_PROTO_USER) && run_mode;
    assign pd_serve[g] = !freeport;
    assign tx_status_flag[g] = tx_flag_reg;
    // a receive needs a max count and a start condition
    assign bad_param = (rxp_reg[23:16] == 8'h00) ||
                       !(rxp_reg[`UPSP_RXP_START_EN] || rxp_reg[`UPSP_RXP_ANY_EN]);

    // request check, first failing condition gives the code
    always_comb begin
      req_hit[g] = cmd_wr && (snd || receive_request);
      req_err[g] = 16'h0000;
      if (snd && receive_request) req_err[g] = (g == 0) ? `UPSP_ERR_SIM0 : `UPSP_ERR_SIM1;
      else if (!freeport) req_err[g] = `UPSP_ERR_MODE;
      else if (snd && !tx_flag_reg) req_err[g] = `UPSP_ERR_BUSY;
      else if (receive_request && rxon && bad_param) req_err[g] = `UPSP_ERR_PARAM;
    end

    // control, parameter and buffer registers written by software
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        ctrl_reg <= 8'h00;
        rxp_reg <= 32'h0000_0000;
        tmo_reg <= 16'h0000;
        rd_idx_reg <= 8'h00;
      end else begin
        if (wr_here && ofs == `UPSP_OFS_CTRL) ctrl_reg <= avs_writedata[7:0];
        if (wr_here && ofs == `UPSP_OFS_RXP) rxp_reg <= avs_writedata;
        if (wr_here && ofs == `UPSP_OFS_TMO) tmo_reg <= avs_writedata[15:0];
        if (wr_here && ofs == `UPSP_OFS_RXBUF) rd_idx_reg <= avs_writedata[7:0];
        if (run_q_reg && !run_mode) ctrl_reg[1:0] <= 2'h0;
      end
    end

    // transmit buffer, index in [15:8], character in [7:0]
    always_ff @(posedge clk_sys) begin
      if (wr_here && ofs == `UPSP_OFS_TXBUF) tx_mem[avs_writedata[15:8]] <= avs_writedata[7:0];
    end

    // register read view of this port
    always_comb begin
      rd_port[g] = 32'h0000_0000;
      unique case (ofs)
        `UPSP_OFS_CTRL: rd_port[g] = {24'h0, ctrl_reg};
        `UPSP_OFS_STAT: rd_port[g] = {29'h0, freeport, rx_act_reg, tx_flag_reg};
        `UPSP_OFS_RXST: rd_port[g] = {24'h0, rx_stat_reg};
        `UPSP_OFS_RXP: rd_port[g] = rxp_reg;
        `UPSP_OFS_TMO: rd_port[g] = {16'h0, tmo_reg};
        `UPSP_OFS_RXBUF: rd_port[g] = {24'h0, (rd_idx_reg == 8'h00) ? rx_cnt_reg
                                                 : rx_mem[rd_idx_reg]};
        default: rd_port[g] = 32'h0000_0000;
      endcase
    end

    // transmitter
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        tx_state <= TX_IDLE;
        tx_left_reg <= 8'h00;
        tx_ptr_reg <= 8'h00;
        tx_frm_reg <= 11'h7FF;
        tx_bit_reg <= 5'h00;
        tx_tmr_reg <= 17'h0_0000;
        tx_flag_reg <= 1'b1;
        tx_done_reg <= 1'b0;
        ser_txd[g] <= 1'b1;
      end else begin
        tx_done_reg <= 1'b0;
        unique case (tx_state)
          TX_IDLE: begin
            if (req_hit[g] && req_err[g] == 16'h0000 && snd) begin
              tx_flag_reg <= 1'b0;
              tx_ptr_reg <= 8'h00;
              tx_left_reg <= avs_writedata[7:0];
              tx_tmr_reg <= div - 17'h1;
              if (avs_writedata[7:0] == 8'h00) begin
                ser_txd[g] <= 1'b0;
                tx_bit_reg <= `UPSP_BREAK_BITS;
                tx_state <= TX_BRK;
              end else begin
                tx_state <= TX_NEXT;
              end
            end
          end
          TX_NEXT: begin
            tx_frm_reg <= build_frame(ctrl_reg, tx_mem[tx_ptr_reg]);
            tx_bit_reg <= frame_bits(ctrl_reg);
            tx_tmr_reg <= div - 17'h1;
            ser_txd[g] <= 1'b0;
            tx_ptr_reg <= tx_ptr_reg + 8'h1;
            tx_left_reg <= tx_left_reg - 8'h1;
            tx_state <= TX_SEND;
          end
          TX_SEND: begin
            if (tx_tmr_reg != 17'h0_0000) begin
              tx_tmr_reg <= tx_tmr_reg - 17'h1;
            end else if (tx_bit_reg == 5'h01) begin
              if (tx_left_reg == 8'h00) begin
                tx_flag_reg <= 1'b1;
                tx_done_reg <= 1'b1;
                tx_state <= TX_IDLE;
              end else begin
                tx_state <= TX_NEXT;
              end
            end else begin
              tx_frm_reg <= {1'b1, tx_frm_reg[10:1]};
              ser_txd[g] <= tx_frm_reg[1];
              tx_bit_reg <= tx_bit_reg - 5'h1;
              tx_tmr_reg <= div - 17'h1;
            end
          end
          TX_BRK: begin
            if (tx_tmr_reg != 17'h0_0000) begin
              tx_tmr_reg <= tx_tmr_reg - 17'h1;
            end else if (tx_bit_reg == 5'h01) begin
              ser_txd[g] <= 1'b1;
              tx_flag_reg <= 1'b1;
              tx_done_reg <= 1'b1;
              tx_state <= TX_IDLE;
            end else begin
              tx_bit_reg <= tx_bit_reg - 5'h1;
              tx_tmr_reg <= div - 17'h1;
            end
          end
        endcase
      end
    end

    // line input: three stages, level taken once the last two agree
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        rx1_reg <= 1'b1;
        rx2_reg <= 1'b1;
        rx3_reg <= 1'b1;
        rx_lvl_reg <= 1'b1;
      end else begin
        rx1_reg <= ser_rxd[g];
        rx2_reg <= rx1_reg;
        rx3_reg <= rx2_reg;
        if (rx2_reg == rx3_reg) rx_lvl_reg <= rx3_reg;
      end
    end

    // character receiver, samples at mid bit
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        rx_state <= RX_IDLE;
        rx_bits_reg <= 10'h000;
        rx_idx_reg <= 4'h0;
        rx_tmr_reg <= 17'h0_0000;
        chr_vld_reg <= 1'b0;
      end else begin
        chr_vld_reg <= 1'b0;
        unique case (rx_state)
          RX_IDLE: begin
            if (!rx_lvl_reg) begin
              rx_tmr_reg <= {1'b0, div[16:1]};
              rx_state <= RX_HALF;
            end
          end
          RX_HALF: begin
            if (rx_tmr_reg != 17'h0_0000) begin
              rx_tmr_reg <= rx_tmr_reg - 17'h1;
            end else if (!rx_lvl_reg) begin
              rx_tmr_reg <= div - 17'h1;
              rx_idx_reg <= 4'h0;
              rx_state <= RX_BITS;
            end else begin
              rx_state <= RX_IDLE;
            end
          end
          RX_BITS: begin
            if (rx_tmr_reg != 17'h0_0000) begin
              rx_tmr_reg <= rx_tmr_reg - 17'h1;
            end else begin
              rx_bits_reg[rx_idx_reg] <= rx_lvl_reg;
              rx_tmr_reg <= div - 17'h1;
              if (5'(rx_idx_reg) == frame_bits(ctrl_reg) - 5'h2) begin
                chr_vld_reg <= freeport;
                rx_state <= RX_IDLE;
              end else begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end

    // received character and its parity check
    assign ch = ctrl_reg[5] ? {1'b0, rx_bits_reg[6:0]} : rx_bits_reg[7:0];
    assign perr = ctrl_reg[6] &&
                  (rx_bits_reg[ctrl_reg[5] ? 7 : 8] != (^ch ^ ctrl_reg[7]));
    assign tmo_hit = (tmo_reg != 16'h0000) &&
                     (tmo_cnt_reg >= 33'(tmo_reg) * 33'(div));

    // message buffer: index 0 is the count, characters from index 1
    always_ff @(posedge clk_sys) begin
      if (rx_act_reg && chr_vld_reg && !perr &&
          (rx_started_reg || !rxp_reg[`UPSP_RXP_START_EN] || ch == rxp_reg[7:0]))
        rx_mem[rx_cnt_reg + 8'h1] <= ch;
    end

    // message receive control and status byte {n r e 0 0 t c p}
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        rx_act_reg <= 1'b0;
        rx_started_reg <= 1'b0;
        rx_done_reg <= 1'b0;
        rx_cnt_reg <= 8'h00;
        rx_stat_reg <= `UPSP_RXST_RESET;
        tmo_cnt_reg <= 33'h0;
      end else begin
        rx_done_reg <= 1'b0;
        tmo_cnt_reg <= (rx_act_reg && rx_started_reg && !chr_vld_reg)
                       ? tmo_cnt_reg + 33'h1 : 33'h0;
        if (req_hit[g] && receive_request && !snd && freeport) begin
          if (!rxon) begin
            if (rx_act_reg) rx_stat_reg <= 8'h80;
            rx_act_reg <= 1'b0;
          end else if (bad_param) begin
            rx_stat_reg <= rx_stat_reg | 8'h40;
            rx_act_reg <= 1'b0;
          end else begin
            rx_act_reg <= 1'b1;
            rx_started_reg <= 1'b0;
            rx_cnt_reg <= 8'h00;
            rx_stat_reg <= 8'h00;
          end
        end else if (rx_act_reg && !freeport) begin
          rx_act_reg <= 1'b0;
          rx_stat_reg <= 8'h80;
        end else if (rx_act_reg && chr_vld_reg) begin
          if (perr) begin
            rx_act_reg <= 1'b0;
            rx_stat_reg <= 8'h01;
          end else if (rx_started_reg || !rxp_reg[`UPSP_RXP_START_EN] ||
                       ch == rxp_reg[7:0]) begin
            rx_started_reg <= 1'b1;
            rx_cnt_reg <= rx_cnt_reg + 8'h1;
            if (rxp_reg[`UPSP_RXP_END_EN] && ch == rxp_reg[15:8]) begin
              rx_act_reg <= 1'b0;
              rx_stat_reg <= 8'h20;
              rx_done_reg <= 1'b1;
            end else if (rx_cnt_reg + 8'h1 == rxp_reg[23:16]) begin
              rx_act_reg <= 1'b0;
              rx_stat_reg <= 8'h02;
              rx_done_reg <= 1'b1;
            end
          end
        end else if (rx_act_reg && rx_started_reg && tmo_hit) begin
          rx_act_reg <= 1'b0;
          rx_stat_reg <= 8'h04;
          rx_done_reg <= 1'b1;
        end
      end
    end

    // completion events with fixed per-port ids
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        evt[g] <= '0;
      end else begin
        evt[g].tx_done <= tx_done_reg;
        evt[g].rx_done <= rx_done_reg;
        evt[g].tx_id <= (g == 0) ? `UPSP_EVT_TX0 : `UPSP_EVT_TX1;
        evt[g].rx_id <= (g == 0) ? `UPSP_EVT_RX0 : `UPSP_EVT_RX1;
      end
    end
  end

endmodule

// ===== testbench/tb_upsp_serial_port.sv
// testbench for the serial port: register traffic, frames and verdict
`timescale 1ns/1ns
module tb_upsp_serial_port
  import upsp_pkg::*;
;
  localparam int DIV = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdat, lfsr;
  logic avs_waitrequest, ok_output, dev_tx, rxd1, listen, pe, po;
  logic run_mode = 1'b1;
  logic mode_switch_pin = 1'b1;
  logic [1:0] ser_txd, pd_serve, tx_status_flag;
  logic [3:0] nb;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  upsp_evt_s [1:0] evt;
  int mismatches = 0;
  int total_checks = 0;
  int low_n = 0;
  int brk_len = 0;
  initial begin
    rxd1 = 1'b1;
    listen = 1'b1;
    pe = 1'b0;
    po = 1'b0;
    nb = 4'h8;
    lfsr = 32'hCE19;
  end
  always #5 clk_sys = ~clk_sys;
  upsp_serial_port #(.NP(2), .CLK_HZ(384000)) u_upsp_serial_port (.clk_sys(clk_sys),
    .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_mode(run_mode), .mode_switch_pin(mode_switch_pin),
    .ser_rxd({rxd1, dev_tx}), .ser_txd(ser_txd), .pd_serve(pd_serve),
    .tx_status_flag(tx_status_flag), .evt(evt), .ok_output(ok_output));
  upsp_ser_dev u_upsp_ser_dev (.clk_sys(clk_sys), .line_in(ser_txd[0]), .line_out(dev_tx),
    .div(16'(DIV)), .nbits(nb), .par_en(pe), .par_odd(po), .listen(listen));
  // length of the last low stretch on port 0
  always @(posedge clk_sys) begin
    if (ser_txd[0] === 1'b0) low_n <= low_n + 1;
    else if (low_n != 0) begin
      brk_len <= low_n;
      low_n <= 0;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    chk(rdat, e);
  endtask
  task automatic wait_evt(input logic rx);
    int n;
    n = 0;
    while ((rx ? evt[0].rx_done : evt[0].tx_done) !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 20000), 32'h1);
  endtask
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rc(8'h10, 32'h80);
    rc(8'h80, 32'h1);
    wr(8'h04, 32'h101);
    rc(8'h84, 32'h100);
    for (int p = 0; p < 2; p++) begin
      wr(8'(p * 64), 32'h01);
      wr(8'(p * 64 + 4), 32'h301);
      rc(8'h84, p ? 32'h000B : 32'h0009);
    end
    chk(32'(pd_serve), 32'h0);
    for (int c = 0; c < 2; c++) begin
      nb = c ? 4'h7 : 4'h8;
      pe = c[0];
      po = c[0];
      wr(8'h00, c ? 32'hE1 : 32'h01);
      for (int i = 1; i <= 3; i++) begin
        lfsr = nxt(lfsr);
        b = lfsr[7:0] & (c ? 8'h7F : 8'hFF);
        exp_q.push_back(b);
        wr(8'h18, {16'h0, 8'(i - 1), b});
      end
      wr(8'h04, 32'h103);
      wr(8'h04, 32'h103);
      rc(8'h84, 32'h101);
      wait_evt(1'b0);
      chk(32'(evt[0].tx_id), 32'h09);
      chk(32'(tx_status_flag[0]), 32'h1);
      repeat (5) @(posedge clk_sys);
      while (exp_q.size() > 0) chk(32'(u_upsp_ser_dev.got.pop_front()), 32'(exp_q.pop_front()));
    end
    chk(u_upsp_ser_dev.errs, 0);
    listen = 1'b0;
    wr(8'h00, 32'h05);
    wr(8'h04, 32'h100);
    wait_evt(1'b0);
    chk(brk_len, 16 * 2 * DIV);
    chk(32'(evt[0].tx_id), 32'h09);
    listen = 1'b1;
    pe = 1'b0;
    nb = 4'h8;
    wr(8'h00, 32'h01);
    wr(8'h14, 32'h06FF0D00);
    wr(8'h04, 32'h600);
    rc(8'h10, 32'h0);
    exp_q.push_back(8'h03);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      b = (i == 2) ? 8'h0D : (lfsr[7:0] | 8'h80);
      exp_q.push_back(b);
      u_upsp_ser_dev.send_byte(b);
    end
    wait_evt(1'b1);
    chk(32'(evt[0].rx_id), 32'h17);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1C, 32'(i));
      rc(8'h1C, 32'(exp_q.pop_front()));
    end
    rc(8'h10, 32'h20);
    wr(8'h04, 32'h600);
    wr(8'h04, 32'h200);
    rc(8'h10, 32'h80);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h600);
    rc(8'h84, 32'h102);
    rc(8'h10, 32'hC0);
    wr(8'h00, 32'h41);
    wr(8'h14, 32'h06FF0D00);
    wr(8'h04, 32'h600);
    u_upsp_ser_dev.send_byte(8'h03);
    repeat (20) @(posedge clk_sys);
    rc(8'h10, 32'h01);
    mode_switch_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc(8'h80, 32'h0);
    run_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'(pd_serve), 32'h3);
    run_mode <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'(pd_serve), 32'h3);
    wr(8'h04, 32'h101);
    rc(8'h84, 32'h100);
    finish_test();
  end
endmodule

// ===== testbench/upsp_ser_dev.sv
// far-side serial device model: frame decoder and frame sender
`timescale 1ns/1ns
module upsp_ser_dev (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out,
  input wire logic [15:0] div,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic listen
);
  logic [7:0] got[$];
  int errs = 0;
  initial line_out = 1'b1;
  // decoder: mid-bit sampling, lsb first, parity and single stop checked
  always begin
    logic [7:0] d;
    logic p;
    @(negedge line_in);
    if (listen) begin
      d = 8'h00;
      repeat (div / 2) @(posedge clk_sys);
      if (line_in !== 1'b0) errs++;
      for (int i = 0; i < nbits; i++) begin
        repeat (div) @(posedge clk_sys);
        d[i] = line_in;
      end
      p = (^d) ^ par_odd;
      if (par_en) begin
        repeat (div) @(posedge clk_sys);
        if (line_in !== p) errs++;
      end
      repeat (div) @(posedge clk_sys);
      if (line_in !== 1'b1) errs++;
      got.push_back(d);
    end
  end
  // sender: start low, eight data bits lsb first, one stop, idle high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (div) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== testbench/upsp_serial_port_asserts.sv
// port-level assertions for the serial port, bound into the design
`timescale 1ns/1ns
`include "upsp_consts.svh"
module upsp_serial_port_asserts
  import upsp_pkg::*;
#(
  parameter int NP = 2,
  parameter int CLK_HZ = `UPSP_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic run_mode,
  input wire logic mode_switch_pin,
  input wire logic [NP-1:0] ser_rxd,
  input wire logic [NP-1:0] ser_txd,
  input wire logic [NP-1:0] pd_serve,
  input wire logic [NP-1:0] tx_status_flag,
  input wire upsp_evt_s [NP-1:0] evt,
  input wire logic ok_output
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic cmd0;
  // ----------------------------------------
  // port 0 command write decode
  // ----------------------------------------
  assign cmd0 = avs_write && avs_address == 8'h04;
  chk_idle_high: assert property (tx_status_flag[0] && $past(tx_status_flag[0]) |-> ser_txd[0])
    else $error("line low while port idle");
  chk_done_pulse: assert property (evt[0].tx_done |=> !evt[0].tx_done)
    else $error("transmit done longer than one cycle");
  chk_tx_id: assert property (evt[0].tx_done |-> evt[0].tx_id == `UPSP_EVT_TX0)
    else $error("wrong transmit event id");
  chk_rx_id: assert property (evt[0].rx_done |-> evt[0].rx_id == `UPSP_EVT_RX0)
    else $error("wrong receive event id");
  chk_send_start: assert property (cmd0 && avs_writedata[8] && !avs_writedata[9]
    && tx_status_flag[0] && !pd_serve[0] |=> !tx_status_flag[0] ##[0:2] !ser_txd[0])
    else $error("accepted send did not start");
  chk_busy_refuse: assert property (cmd0 && avs_writedata[8] && !avs_writedata[9]
    && !tx_status_flag[0] |=> !ok_output)
    else $error("send while busy not refused");
  chk_mode_refuse: assert property (cmd0 && |avs_writedata[9:8] && pd_serve[0] |=> !ok_output)
    else $error("request outside user mode not refused");
  chk_both_refuse: assert property (cmd0 && &avs_writedata[9:8] |=> !ok_output)
    else $error("send with receive not refused");
  chk_run_drop: assert property (!run_mode [*2] |-> &pd_serve)
    else $error("user mode kept outside run");
  chk_flag_done: assert property ($rose(tx_status_flag[0]) |=> evt[0].tx_done)
    else $error("flag rose without completion event");
  cov_tx: cover property (evt[0].tx_done);
  cov_rx: cover property (evt[0].rx_done);
  cov_brk: cover property (cmd0 && avs_writedata[8] && avs_writedata[7:0] == 8'h00);
endmodule
bind upsp_serial_port upsp_serial_port_asserts #(.NP(NP), .CLK_HZ(CLK_HZ)) u_upsp_serial_port_asserts (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .run_mode(run_mode), .mode_switch_pin(mode_switch_pin),
  .ser_rxd(ser_rxd), .ser_txd(ser_txd), .pd_serve(pd_serve), .tx_status_flag(tx_status_flag),
  .evt(evt), .ok_output(ok_output));
